//--- common/rfc_pkg.sv
// Notes on behaviour
// - per-port undersize threshold, five low bits kept, resets to eight bytes
// - frame shorter than threshold, preamble and delimiter excluded, is short
// - frame at or above threshold but under 64 bytes is a runt
// - short and runt classes apply only in copper mode
// - discard bit clear, its reset value, forwards unknown control frames
// - only pause frames count as known control frames
// - partner negotiation register serves fiber-mode negotiation and receive status only
// - low sixteen bits show the latest configuration word from the partner
// - done flag bit 21 clear from negotiation reset until link up, then held
// - done flag meaningful only while negotiation is enabled
// - sync flag bit 20 is one while synced, latched low until read
package rfc_pkg;
   localparam logic [7:0]  RFC_IDX_THRESH   = 8'h14;
   localparam logic [7:0]  RFC_IDX_POLICY   = 8'h15;
   localparam logic [7:0]  RFC_IDX_PARTNER  = 8'h16;
   localparam int          RFC_ADDR_W       = 12;
   localparam int          RFC_THR_W        = 5;
   localparam logic [4:0]  RFC_THR_RESET    = 5'h08;
   localparam logic [0:0]  RFC_POLICY_RESET = 1'h0;
   localparam int          RFC_POLICY_BIT   = 0;
   localparam int          RFC_WORD_W       = 16;
   localparam int          RFC_SYNC_BIT     = 20;
   localparam int          RFC_DONE_BIT     = 21;
   localparam int          RFC_LEN_W        = 14;
   localparam int          RFC_MIN_FRAME    = 64;
   localparam logic [31:0] RFC_RDATA_RESET  = 32'h0000_0000;

   // negotiation progress, gray coded along the usual path
   typedef enum logic [1:0] {
      RFC_AN_OFF  = 2'b00,
      RFC_AN_WAIT = 2'b01,
      RFC_AN_DONE = 2'b11
   } rfc_an_t;

   // byte address of a register given its printed index
   function automatic logic [RFC_ADDR_W-1:0] rfc_byte_addr(input logic [7:0] idx);
      rfc_byte_addr = {{(RFC_ADDR_W-10){1'b0}}, idx, 2'b00};
   endfunction : rfc_byte_addr
endpackage : rfc_pkg

//--- common/rfc_cls_if.sv
interface rfc_cls_if
   import rfc_pkg::*;
#(
   parameter int LEN_W = RFC_LEN_W
);
   logic                 ce;
   logic                 frame_end;
   logic [LEN_W-1:0]     frame_len;
   logic                 frame_ctrl;
   logic                 frame_pause;
   logic                 copper;
   logic [RFC_THR_W-1:0] thresh;
   logic                 discard;
   logic                 res_valid;
   logic                 res_short;
   logic                 res_runt;
   logic                 res_deliver;
   logic                 res_drop;

   modport core (output ce, frame_end, frame_len, frame_ctrl, frame_pause, copper,
                 thresh, discard,
                 input  res_valid, res_short, res_runt, res_deliver, res_drop);
   modport cls  (input  ce, frame_end, frame_len, frame_ctrl, frame_pause, copper,
                 thresh, discard,
                 output res_valid, res_short, res_runt, res_deliver, res_drop);
endinterface : rfc_cls_if

//--- design/rfc_classifier.sv
module rfc_classifier
   import rfc_pkg::*;
#(
   parameter int LEN_W = RFC_LEN_W
) (
   input  wire logic clk_in,   // core clock
   input  wire logic rst_in,   // synchronous reset, high
   rfc_cls_if.cls    cls       // frame info and verdict
);
   localparam logic [LEN_W-1:0] MIN_FRAME = LEN_W'(RFC_MIN_FRAME);

   logic [LEN_W-1:0] thr_ext;
   logic             below_thr;
   logic             below_min;
   logic             unknown_ctrl;

   assign thr_ext      = LEN_W'(cls.thresh);
   assign below_thr    = cls.frame_len < thr_ext;
   assign below_min    = cls.frame_len < MIN_FRAME;
   assign unknown_ctrl = cls.frame_ctrl && !cls.frame_pause;

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         cls.res_valid <= 1'b0;
      end else if (cls.ce) begin
         cls.res_valid <= cls.frame_end;
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         cls.res_short <= 1'b0;
         cls.res_runt  <= 1'b0;
      end else if (cls.ce) begin
         cls.res_short <= cls.frame_end && cls.copper && below_thr;
         cls.res_runt  <= cls.frame_end && cls.copper && !below_thr && below_min;
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         cls.res_deliver <= 1'b0;
         cls.res_drop    <= 1'b0;
      end else if (cls.ce) begin
         cls.res_drop    <= cls.frame_end && unknown_ctrl && cls.discard;
         cls.res_deliver <= cls.frame_end && !(unknown_ctrl && cls.discard);
      end
   end
endmodule : rfc_classifier

//--- design/rfc_top.sv
// The APB interface to the registers was left to the implementer.
module rfc_top
   import rfc_pkg::*;
#(
   parameter int LEN_W = RFC_LEN_W
) (
   input  wire logic                  CLOCK_IN,          // core clock, 40 MHz
   input  wire logic                  RST_IN,            // synchronous reset, high
   input  wire logic                  CE_IN,             // clock enable, low freezes
   input  wire logic                  PSEL_IN,           // apb select
   input  wire logic                  PENABLE_IN,        // apb access phase
   input  wire logic                  PWRITE_IN,         // apb write
   input  wire logic [RFC_ADDR_W-1:0] PADDR_IN,          // apb byte address
   input  wire logic [31:0]           PWDATA_IN,         // apb write data
   input  wire logic [3:0]            PSTRB_IN,          // apb byte strobes
   output logic      [31:0]           PRDATA_OUT,        // apb read data
   output logic                       PREADY_OUT,        // apb ready
   output logic                       PSLVERR_OUT,       // apb error, unmapped
   input  wire logic                  COPPER_MODE_IN,    // 1 copper, 0 fiber
   input  wire logic                  FRAME_END_IN,      // received frame done
   input  wire logic [LEN_W-1:0]      FRAME_LEN_IN,      // bytes, no preamble/sfd
   input  wire logic                  FRAME_CTRL_IN,     // mac control frame
   input  wire logic                  FRAME_PAUSE_IN,    // control frame is pause
   output logic                       CLASS_VALID_OUT,   // verdict pulse
   output logic                       CLASS_SHORT_OUT,   // frame was short
   output logic                       CLASS_RUNT_OUT,    // frame was runt
   output logic                       FRAME_DELIVER_OUT, // pass to system side
   output logic                       FRAME_DROP_OUT,    // discard frame
   input  wire logic                  CFG_WORD_VALID_IN, // partner word strobe
   input  wire logic [RFC_WORD_W-1:0] CFG_WORD_IN,       // partner config word
   input  wire logic                  AN_ENABLE_IN,      // negotiation enabled
   input  wire logic                  AN_RESTART_IN,     // negotiation restart
   input  wire logic                  AN_LINK_OK_IN,     // link-up state reached
   input  wire logic                  RX_SYNC_IN,        // bit sync held
   output logic                       NEG_DONE_OUT       // negotiation_done_flag
);
   localparam logic [RFC_ADDR_W-1:0] ADDR_THRESH  = rfc_byte_addr(RFC_IDX_THRESH);
   localparam logic [RFC_ADDR_W-1:0] ADDR_POLICY  = rfc_byte_addr(RFC_IDX_POLICY);
   localparam logic [RFC_ADDR_W-1:0] ADDR_PARTNER = rfc_byte_addr(RFC_IDX_PARTNER);

   logic                  setup_phase;
   logic                  access_done;
   logic                  wr_done;
   logic                  rd_done;
   logic                  hit_thresh;
   logic                  hit_policy;
   logic                  hit_partner;
   logic                  mapped;
   logic                  partner_read;

   logic [RFC_THR_W-1:0]  undersize_threshold;
   logic                  unknown_ctrl_discard;
   logic [RFC_WORD_W-1:0] partner_word;
   logic                  rx_sync_flag;
   rfc_an_t               an_state;
   rfc_an_t               next_an_state;
   logic                  fiber_an;
   logic [31:0]           next_rdata;

   rfc_cls_if #(.LEN_W(LEN_W)) cls_bus ();

   // register bus decode
   assign setup_phase  = PSEL_IN && !PENABLE_IN;
   assign access_done  = PSEL_IN && PENABLE_IN && CE_IN;
   assign hit_thresh   = PADDR_IN == ADDR_THRESH;
   assign hit_policy   = PADDR_IN == ADDR_POLICY;
   assign hit_partner  = PADDR_IN == ADDR_PARTNER;
   assign mapped       = hit_thresh || hit_policy || hit_partner;
   assign wr_done      = access_done && PWRITE_IN && mapped;
   assign rd_done      = access_done && !PWRITE_IN && mapped;
   assign partner_read = rd_done && hit_partner;

   assign PREADY_OUT  = CE_IN;
   assign PSLVERR_OUT = PSEL_IN && PENABLE_IN && !mapped;

   // threshold register, low five bits only
   always_ff @(posedge CLOCK_IN) begin
      if (RST_IN) begin
         undersize_threshold <= RFC_THR_RESET;
      end else if (CE_IN && wr_done && hit_thresh && PSTRB_IN[0]) begin
         undersize_threshold <= PWDATA_IN[RFC_THR_W-1:0];
      end
   end

   // unknown control frame policy
   always_ff @(posedge CLOCK_IN) begin
      if (RST_IN) begin
         unknown_ctrl_discard <= RFC_POLICY_RESET[0];
      end else if (CE_IN && wr_done && hit_policy && PSTRB_IN[0]) begin
         unknown_ctrl_discard <= PWDATA_IN[RFC_POLICY_BIT];
      end
   end

   // partner word captured in fiber mode only
   always_ff @(posedge CLOCK_IN) begin
      if (RST_IN) begin
         partner_word <= '0;
      end else if (CE_IN && CFG_WORD_VALID_IN && !COPPER_MODE_IN) begin
         partner_word <= CFG_WORD_IN;
      end
   end

   // sync flag latches low; loss beats a concurrent read
   always_ff @(posedge CLOCK_IN) begin
      if (RST_IN) begin
         rx_sync_flag <= 1'b0;
      end else if (CE_IN) begin
         if (!RX_SYNC_IN || COPPER_MODE_IN) begin
            rx_sync_flag <= 1'b0;
         end else if (partner_read) begin
            rx_sync_flag <= 1'b1;
         end
      end
   end

   // negotiation progress
   assign fiber_an = AN_ENABLE_IN && !COPPER_MODE_IN;

   always_comb begin
      next_an_state = an_state;
      case (an_state)
         RFC_AN_OFF: begin
            if (fiber_an) begin
               next_an_state = RFC_AN_WAIT;
            end
         end
         RFC_AN_WAIT: begin
            if (!fiber_an || AN_RESTART_IN) begin
               next_an_state = fiber_an ? RFC_AN_WAIT : RFC_AN_OFF;
            end else if (AN_LINK_OK_IN) begin
               next_an_state = RFC_AN_DONE;
            end
         end
         RFC_AN_DONE: begin
            if (!fiber_an) begin
               next_an_state = RFC_AN_OFF;
            end else if (AN_RESTART_IN) begin
               next_an_state = RFC_AN_WAIT;
            end
         end
         default: begin
            next_an_state = RFC_AN_OFF;
         end
      endcase
   end

   always_ff @(posedge CLOCK_IN) begin
      if (RST_IN) begin
         an_state <= RFC_AN_OFF;
      end else if (CE_IN) begin
         an_state <= next_an_state;
      end
   end

   always_ff @(posedge CLOCK_IN) begin
      if (RST_IN) begin
         NEG_DONE_OUT <= 1'b0;
      end else if (CE_IN) begin
         NEG_DONE_OUT <= next_an_state == RFC_AN_DONE;
      end
   end

   // read data prepared in the setup cycle
   always_comb begin
      next_rdata = '0;
      if (hit_thresh) begin
         next_rdata[RFC_THR_W-1:0] = undersize_threshold;
      end else if (hit_policy) begin
         next_rdata[RFC_POLICY_BIT] = unknown_ctrl_discard;
      end else if (hit_partner) begin
         next_rdata[RFC_WORD_W-1:0] = partner_word;
         next_rdata[RFC_SYNC_BIT]   = rx_sync_flag;
         next_rdata[RFC_DONE_BIT]   = NEG_DONE_OUT;
      end
   end

   always_ff @(posedge CLOCK_IN) begin
      if (RST_IN) begin
         PRDATA_OUT <= RFC_RDATA_RESET;
      end else if (CE_IN && setup_phase && !PWRITE_IN) begin
         PRDATA_OUT <= next_rdata;
      end
   end

   // frame classification
   assign cls_bus.ce          = CE_IN;
   assign cls_bus.frame_end   = FRAME_END_IN;
   assign cls_bus.frame_len   = FRAME_LEN_IN;
   assign cls_bus.frame_ctrl  = FRAME_CTRL_IN;
   assign cls_bus.frame_pause = FRAME_PAUSE_IN;
   assign cls_bus.copper      = COPPER_MODE_IN;
   assign cls_bus.thresh      = undersize_threshold;
   assign cls_bus.discard     = unknown_ctrl_discard;

   rfc_classifier #(
      .LEN_W (LEN_W)
   ) u_classifier (
      .clk_in (CLOCK_IN),
      .rst_in (RST_IN),
      .cls    (cls_bus)
   );

   assign CLASS_VALID_OUT   = cls_bus.res_valid;
   assign CLASS_SHORT_OUT   = cls_bus.res_short;
   assign CLASS_RUNT_OUT    = cls_bus.res_runt;
   assign FRAME_DELIVER_OUT = cls_bus.res_deliver;
   assign FRAME_DROP_OUT    = cls_bus.res_drop;
endmodule : rfc_top

//--- test/rfc_top_properties.sv
module rfc_top_properties
   import rfc_pkg::*;
#(
   parameter int LEN_W = RFC_LEN_W
) (
   input wire logic             CLOCK_IN,          // core clock
   input wire logic             RST_IN,            // sync reset
   input wire logic             CE_IN,             // clock enable
   input wire logic             COPPER_MODE_IN,    // copper mode
   input wire logic             FRAME_END_IN,      // frame done
   input wire logic [LEN_W-1:0] FRAME_LEN_IN,      // frame length
   input wire logic             FRAME_CTRL_IN,     // control frame
   input wire logic             FRAME_PAUSE_IN,    // pause frame
   input wire logic             CLASS_VALID_OUT,   // verdict pulse
   input wire logic             CLASS_SHORT_OUT,   // short
   input wire logic             CLASS_RUNT_OUT,    // runt
   input wire logic             FRAME_DELIVER_OUT, // deliver
   input wire logic             FRAME_DROP_OUT,    // drop
   input wire logic             AN_ENABLE_IN,      // negotiation on
   input wire logic             AN_LINK_OK_IN,     // link up
   input wire logic             NEG_DONE_OUT       // done flag
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge CLOCK_IN);
   endclocking
   default disable iff (RST_IN);
   sequence s_taken;
      FRAME_END_IN && CE_IN;
   endsequence
   sequence s_verdict;
      ##1 CLASS_VALID_OUT;
   endsequence
   a_verdict_next: assert property (s_taken |-> s_verdict)
      else $error("no verdict after frame end");
   a_verdict_cause: assert property (CLASS_VALID_OUT |-> $past(FRAME_END_IN && CE_IN))
      else $error("verdict without frame");
   a_one_fate: assert property (CLASS_VALID_OUT |-> FRAME_DELIVER_OUT != FRAME_DROP_OUT)
      else $error("deliver and drop not exclusive");
   a_fiber_no_class: assert property (s_taken ##0 !COPPER_MODE_IN |=>
      !CLASS_SHORT_OUT && !CLASS_RUNT_OUT) else $error("class set in fiber mode");
   a_long_no_runt: assert property (s_taken ##0 FRAME_LEN_IN >= LEN_W'(RFC_MIN_FRAME) |=>
      !CLASS_SHORT_OUT && !CLASS_RUNT_OUT) else $error("long frame classed");
   a_known_deliver: assert property (s_taken ##0 (!FRAME_CTRL_IN || FRAME_PAUSE_IN) |=>
      FRAME_DELIVER_OUT) else $error("known frame not delivered");
   a_idle_quiet: assert property (!CLASS_VALID_OUT |->
      !(CLASS_SHORT_OUT || CLASS_RUNT_OUT || FRAME_DELIVER_OUT || FRAME_DROP_OUT))
      else $error("verdict bits outside pulse");
   a_done_off: assert property (!AN_ENABLE_IN && CE_IN |=> !NEG_DONE_OUT)
      else $error("done while negotiation off");
   a_done_cause: assert property ($rose(NEG_DONE_OUT) |-> $past(AN_LINK_OK_IN && AN_ENABLE_IN))
      else $error("done rose without link up");
endmodule : rfc_top_properties

bind rfc_top rfc_top_properties #(.LEN_W(LEN_W)) u_rfc_top_properties (.*);

//--- test/rfc_link_partner.sv
module rfc_link_partner
   import rfc_pkg::*;
(
   input  wire logic                  clk_in,       // core clock
   output logic                       end_out,      // frame done strobe
   output logic      [RFC_LEN_W-1:0]  len_out,      // frame length
   output logic                       ctrl_out,     // control frame
   output logic                       pause_out,    // pause frame
   output logic                       word_vld_out, // word strobe
   output logic      [RFC_WORD_W-1:0] word_out,     // partner word
   output logic                       sync_out      // bit sync held
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      {end_out, len_out, ctrl_out, pause_out, word_vld_out, word_out} = '0;
      sync_out = 1'b1;
   end
   // released fields show inverted values, never the old ones
   task automatic send_frame(input logic [RFC_LEN_W-1:0] len, input logic ct, input logic pa);
      {end_out, len_out, ctrl_out, pause_out} <= {1'b1, len, ct, pa};
      @(posedge clk_in);
      {end_out, len_out, ctrl_out, pause_out} <= {1'b0, ~len, ~ct, ~pa};
   endtask : send_frame
   task automatic send_word(input logic [RFC_WORD_W-1:0] w);
      {word_vld_out, word_out} <= {1'b1, w};
      @(posedge clk_in);
      {word_vld_out, word_out} <= {1'b0, ~w};
   endtask : send_word
   task automatic set_sync(input logic v);
      sync_out <= v;
   endtask : set_sync
endmodule : rfc_link_partner

//--- test/tb.sv
module tb
   import rfc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic                  clk, rst, psel, penable, pwrite, copper, an_en, an_rst, link_ok;
   logic                  pready, err, vld, c_sh, c_ru, c_de, c_dr, done, fe, fc, fp, wv, sync;
   logic                  ce, perr;
   logic [RFC_ADDR_W-1:0] paddr;
   logic [31:0]           pwdata, prdata, q;
   logic [RFC_LEN_W-1:0]  flen;
   logic [RFC_WORD_W-1:0] word, w;
   int                    n_errors, checks_done;
   rfc_top u_rfc_top (.CLOCK_IN(clk), .RST_IN(rst), .CE_IN(ce), .PSEL_IN(psel),
      .PENABLE_IN(penable), .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata),
      .PSTRB_IN(4'hf), .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(err),
      .COPPER_MODE_IN(copper), .FRAME_END_IN(fe), .FRAME_LEN_IN(flen), .FRAME_CTRL_IN(fc),
      .FRAME_PAUSE_IN(fp), .CLASS_VALID_OUT(vld), .CLASS_SHORT_OUT(c_sh),
      .CLASS_RUNT_OUT(c_ru), .FRAME_DELIVER_OUT(c_de), .FRAME_DROP_OUT(c_dr),
      .CFG_WORD_VALID_IN(wv), .CFG_WORD_IN(word), .AN_ENABLE_IN(an_en),
      .AN_RESTART_IN(an_rst), .AN_LINK_OK_IN(link_ok), .RX_SYNC_IN(sync), .NEG_DONE_OUT(done));
   rfc_link_partner u_rfc_link_partner (.clk_in(clk), .end_out(fe), .len_out(flen),
      .ctrl_out(fc), .pause_out(fp), .word_vld_out(wv), .word_out(word), .sync_out(sync));
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         $display("Error %s expected %h seen %h", what, exp, seen);
         n_errors++;
      end
   endtask : check
   task automatic test_done();
      $display("checks %0d mismatches %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : test_done
   task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] d);
      int n;
      @(posedge clk);
      {psel, penable, pwrite, pwdata} <= {2'b10, wr, d};
      paddr <= RFC_ADDR_W'({idx, 2'b00});
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      if (n >= 16) begin
         n_errors++;
         test_done();
      end
      q = prdata;
      perr = err;
      {psel, penable} <= 2'b00;
   endtask : apb
   function automatic logic [31:0] exp_cls(input int len, thr, input logic cu, ct, pa, ds);
      return {28'h0, cu && len < thr, cu && len >= thr && len < RFC_MIN_FRAME,
              !(ct && !pa && ds), ct && !pa && ds};
   endfunction : exp_cls
   initial begin
      int n, thr, len;
      logic cu, ct, pa, ds;
      {rst, psel, penable, pwrite, copper, an_en, an_rst, link_ok} = 8'h80;
      ce = 1'b1;
      paddr = '0;
      pwdata = '0;
      n_errors = 0;
      checks_done = 0;
      void'($urandom(35));
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      apb(0, RFC_IDX_THRESH, 0);
      check("thresh", q, 32'h8);
      apb(0, RFC_IDX_POLICY, 0);
      check("policy", q, 32'h0);
      apb(0, RFC_IDX_PARTNER, 0);
      check("partner", q, 32'h0);
      apb(0, 8'h17, 0);
      check("unmapped err", perr, 1);
      check("unmapped data", q, 32'h0);
      apb(0, RFC_IDX_PARTNER, 0);
      check("sync held", q[20], 1);
      u_rfc_link_partner.set_sync(0);
      repeat (2) @(posedge clk);
      u_rfc_link_partner.set_sync(1);
      apb(0, RFC_IDX_PARTNER, 0);
      check("sync latched", q[20], 0);
      apb(0, RFC_IDX_PARTNER, 0);
      check("sync back", q[20], 1);
      $display("test sync done");
      w = 16'($urandom);
      u_rfc_link_partner.send_word(w);
      copper <= 1'b1;
      @(posedge clk);
      u_rfc_link_partner.send_word(~w);
      copper <= 1'b0;
      apb(1, RFC_IDX_PARTNER, 32'hffff_ffff);
      apb(0, RFC_IDX_PARTNER, 0);
      check("word", q[15:0], w);
      an_en <= 1'b1;
      repeat (5) @(negedge clk);
      check("done early", done, 0);
      @(posedge clk);
      link_ok <= 1'b1;
      for (n = 0; done !== 1'b1 && n < 8; n++) @(negedge clk);
      check("done up", done, 1);
      apb(0, RFC_IDX_PARTNER, 0);
      check("done bit", q[21], 1);
      {link_ok, an_rst} <= 2'b01;
      @(posedge clk);
      an_rst <= 1'b0;
      repeat (4) @(negedge clk);
      check("done restart", done, 0);
      @(posedge clk);
      link_ok <= 1'b1;
      repeat (4) @(negedge clk);
      check("done again", done, 1);
      @(posedge clk);
      an_en <= 1'b0;
      repeat (2) @(negedge clk);
      check("done off", done, 0);
      $display("test negotiation done");
      @(posedge clk);
      ce <= 1'b0;
      u_rfc_link_partner.send_frame(RFC_LEN_W'(5), 1'b0, 1'b0);
      @(negedge clk);
      check("frozen", {pready, vld}, 0);
      @(posedge clk);
      ce <= 1'b1;
      $display("test freeze done");
      for (int i = 0; i < 60; i++) begin
         {thr, ds, cu, ct} = {$urandom_range(31, 0), 3'($urandom)};
         pa = ct & 1'($urandom);
         len = i % 3 == 0 ? thr : i % 3 == 1 ? 63 + i % 2 : $urandom_range(70, 0);
         apb(1, RFC_IDX_THRESH, {27'($urandom), 5'(thr)});
         copper <= cu;
         apb(1, RFC_IDX_POLICY, {31'($urandom), ds});
         apb(0, RFC_IDX_THRESH, 0);
         check("thresh rw", q, thr);
         apb(0, RFC_IDX_POLICY, 0);
         check("policy rw", q, ds);
         u_rfc_link_partner.send_frame(RFC_LEN_W'(len), ct, pa);
         @(negedge clk);
         check("class", {vld, c_sh, c_ru, c_de, c_dr}, exp_cls(len, thr, cu, ct, pa, ds) | 16);
      end
      $display("test frames done");
      @(posedge clk);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      apb(0, RFC_IDX_THRESH, 0);
      check("thresh reset", q, 32'h8);
      apb(0, RFC_IDX_POLICY, 0);
      check("policy reset", q, 32'h0);
      $display("test reset done");
      test_done();
   end
   initial begin
      repeat (20000) @(posedge clk);
      n_errors++;
      test_done();
   end
endmodule : tb
